// ==== common/sso_pkg.sv ====
// package for the subtract and sleep execution slice of an 8-bit core
// assumes a 14-bit instruction word and a four-phase instruction cycle
package sso_pkg;

    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;

    // instruction encodings
    localparam logic [3:0] SUBLIT_TOP_MASK = 4'hE;
    localparam logic [3:0] SUBLIT_TOP_CODE = 4'hC;
    localparam logic [1:0] CLASS_LIT = 2'h3;
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [3:0] SUBFILE_CODE = 4'h2;
    localparam logic [13:0] SLEEP_WORD = 14'h0063;

    // field positions
    localparam int CLASS_HI = 13;
    localparam int CLASS_LO = 12;
    localparam int OPC_HI = 11;
    localparam int OPC_LO = 8;
    localparam int LIT_HI = 7;
    localparam int DEST_BIT = 7;
    localparam int NIBBLE_BIT = 4;

    // reset values
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [7:0] WDT_CLEAR = 8'h00;
    localparam logic TIMEOUT_RESET = 1'b1;
    localparam logic POWERDOWN_RESET = 1'b1;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef enum logic [1:0] {
        SSO_Q1,
        SSO_Q2,
        SSO_Q3,
        SSO_Q4
    } sso_phase_t;

    typedef enum logic [1:0] {
        SSO_OP_NONE,
        SSO_OP_SUBLIT,
        SSO_OP_SUBFILE,
        SSO_OP_SLEEP
    } sso_op_t;

    // status flags touched by this slice
    typedef struct packed {
        logic carry;
        logic nibble_carry_flag;
        logic zero;
        logic timeout_status;
        logic powerdown_status;
    } sso_flags_t;

    // file register write request
    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sso_fwrite_t;

    // sleep side effects, one-cycle pulses except asleep
    typedef struct packed {
        logic wdt_clear;
        logic prescaler_clear;
        logic osc_stop;
        logic asleep;
    } sso_sleep_t;

endpackage

// ==== logic/sso_core.sv ====
// execution slice for literal-subtract, file-subtract and sleep
// assumes the file register read data arrives within q2 for the address on file_addr
// assumes insn, file_rdata and wake come from logic on this clock, so none is synchronised
// assumes the watchdog, prescaler and oscillator outside act on the sleep strobes
// assumes the register file takes a file write in the cycle after q4
// limitation: no other instruction is decoded; any other word runs as a no-operation
//
// Overview of operation
// - literal-subtract: literal minus work register, result into work register
// - literal-subtract word has top bits 11 then 110x, low byte is literal
// - literal-subtract updates carry, nibble carry, zero; other status kept
// - one cycle: decode q1, literal q2, compute q3, write work q4
// - file-subtract opcode 0010: file minus work; dest bit picks work or file
// - carry is 1 when no borrow, 0 when result negative
// - sleep does only decode, enters sleep at q4
// - sleep clears watchdog and prescaler, sets timeout, clears powerdown, stops oscillator
// - sleep is fixed word 00 0000 0110 0011
`timescale 1ns/1ps
module sso_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // instruction fetch
    input wire logic insn_valid,
    input wire logic [sso_pkg::INSN_W-1:0] insn,
    // file register read
    output logic [sso_pkg::FADDR_W-1:0] file_addr,
    input wire logic [sso_pkg::DATA_W-1:0] file_rdata,
    // results
    output logic [sso_pkg::DATA_W-1:0] work_reg,
    output sso_pkg::sso_flags_t flags,
    output sso_pkg::sso_fwrite_t file_write,
    output sso_pkg::sso_sleep_t sleep_ctl,
    output sso_pkg::sso_phase_t phase,
    // wake from sleep, from logic on the same clock
    input wire logic wake
);

    // the whole slice state; pulses and levels alike live here
    typedef struct packed {
        sso_pkg::sso_phase_t phase;
        sso_pkg::sso_op_t op;
        logic [sso_pkg::INSN_W-1:0] insn;
        logic [sso_pkg::DATA_W-1:0] operand;
        logic [sso_pkg::DATA_W-1:0] result;
        logic no_borrow;
        logic nib_no_borrow;
        logic [sso_pkg::DATA_W-1:0] work;
        sso_pkg::sso_flags_t flags;
        sso_pkg::sso_fwrite_t fw;
        sso_pkg::sso_sleep_t slp;
    } sso_state_t;

    sso_state_t st_reg;
    sso_state_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // class bits sit above the opcode nibble in every word
    function automatic logic [1:0] word_class(input logic [sso_pkg::INSN_W-1:0] w);
        return w[sso_pkg::CLASS_HI:sso_pkg::CLASS_LO];
    endfunction

    function automatic logic [3:0] word_opcode(input logic [sso_pkg::INSN_W-1:0] w);
        return w[sso_pkg::OPC_HI:sso_pkg::OPC_LO];
    endfunction

    // the fixed sleep word is tested before the field tests below
    function automatic sso_pkg::sso_op_t decode(input logic [sso_pkg::INSN_W-1:0] w);
        sso_pkg::sso_op_t op;
        op = sso_pkg::SSO_OP_NONE;
        if (w == sso_pkg::SLEEP_WORD) begin
            op = sso_pkg::SSO_OP_SLEEP;
        end else if (word_class(w) == sso_pkg::CLASS_LIT
                && (word_opcode(w) & sso_pkg::SUBLIT_TOP_MASK) == sso_pkg::SUBLIT_TOP_CODE) begin
            // the lowest opcode bit is free, so two codes land here
            op = sso_pkg::SSO_OP_SUBLIT;
        end else if (word_class(w) == sso_pkg::CLASS_BYTE
                && word_opcode(w) == sso_pkg::SUBFILE_CODE) begin
            op = sso_pkg::SSO_OP_SUBFILE;
        end
        return op;
    endfunction

    // both subtracts share one arithmetic and flag path
    function automatic logic is_subtract(input sso_pkg::sso_op_t op);
        return (op == sso_pkg::SSO_OP_SUBLIT) || (op == sso_pkg::SSO_OP_SUBFILE);
    endfunction

    // only a file-subtract with the destination bit set writes the file
    function automatic logic to_file(input sso_pkg::sso_op_t op, input logic [sso_pkg::INSN_W-1:0] w);
        return (op == sso_pkg::SSO_OP_SUBFILE) && w[sso_pkg::DEST_BIT];
    endfunction

    // zero test on the eight-bit result only; the borrow bit plays no part
    function automatic logic is_zero(input logic [sso_pkg::DATA_W-1:0] r);
        return r == sso_pkg::ZERO_BYTE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [sso_pkg::DATA_W:0] diff;
    logic [sso_pkg::NIBBLE_BIT:0] nib_diff;

    always_comb begin
        st_next = st_reg;
        // strobes last one cycle unless a q4 step raises them again
        st_next.fw.we = 1'b0;
        st_next.slp.wdt_clear = 1'b0;
        st_next.slp.prescaler_clear = 1'b0;
        st_next.slp.osc_stop = 1'b0;
        // nine-bit subtract keeps the borrow in the top bit
        diff = {1'b0, st_reg.operand} - {1'b0, st_reg.work};
        nib_diff = {1'b0, st_reg.operand[sso_pkg::NIBBLE_BIT-1:0]} - {1'b0, st_reg.work[sso_pkg::NIBBLE_BIT-1:0]};
        if (st_reg.slp.asleep) begin
            // the phase clock stands while asleep, as with the oscillator stopped
            if (wake) begin
                st_next.slp.asleep = 1'b0;
                st_next.phase = sso_pkg::SSO_Q1;
            end
        end else begin
            case (st_reg.phase)
                sso_pkg::SSO_Q1: begin
                    // a cycle with no word runs as a no-operation
                    if (insn_valid) begin
                        st_next.op = decode(insn);
                    end else begin
                        st_next.op = sso_pkg::SSO_OP_NONE;
                    end
                    st_next.insn = insn;
                    st_next.phase = sso_pkg::SSO_Q2;
                end
                sso_pkg::SSO_Q2: begin
                    case (st_reg.op)
                        sso_pkg::SSO_OP_SUBFILE: begin
                            st_next.operand = file_rdata;
                        end
                        sso_pkg::SSO_OP_SUBLIT: begin
                            st_next.operand = st_reg.insn[sso_pkg::LIT_HI:0];
                        end
                        default: begin
                            // sleep and no-operation read nothing here
                            st_next.operand = st_reg.operand;
                        end
                    endcase
                    st_next.phase = sso_pkg::SSO_Q3;
                end
                sso_pkg::SSO_Q3: begin
                    if (is_subtract(st_reg.op)) begin
                        st_next.result = diff[sso_pkg::DATA_W-1:0];
                        st_next.no_borrow = ~diff[sso_pkg::DATA_W];
                        st_next.nib_no_borrow = ~nib_diff[sso_pkg::NIBBLE_BIT];
                    end else begin
                        // sleep and no-operation compute nothing
                        st_next.result = st_reg.result;
                    end
                    st_next.phase = sso_pkg::SSO_Q4;
                end
                sso_pkg::SSO_Q4: begin
                    case (st_reg.op)
                        sso_pkg::SSO_OP_SUBLIT,
                        sso_pkg::SSO_OP_SUBFILE: begin
                            // only carry, nibble carry and zero move
                            st_next.flags.carry = st_reg.no_borrow;
                            st_next.flags.nibble_carry_flag = st_reg.nib_no_borrow;
                            st_next.flags.zero = is_zero(st_reg.result);
                            if (to_file(st_reg.op, st_reg.insn)) begin
                                st_next.fw.we = 1'b1;
                                st_next.fw.addr = st_reg.insn[sso_pkg::FADDR_W-1:0];
                                st_next.fw.data = st_reg.result;
                            end else begin
                                st_next.work = st_reg.result;
                            end
                        end
                        sso_pkg::SSO_OP_SLEEP: begin
                            // the watchdog, prescaler and oscillator act on these strobes
                            st_next.flags.timeout_status = 1'b1;
                            st_next.flags.powerdown_status = 1'b0;
                            st_next.slp.wdt_clear = 1'b1;
                            st_next.slp.prescaler_clear = 1'b1;
                            st_next.slp.osc_stop = 1'b1;
                            st_next.slp.asleep = 1'b1;
                        end
                        default: begin
                            // a no-operation writes nothing
                            st_next.work = st_reg.work;
                        end
                    endcase
                    st_next.phase = sso_pkg::SSO_Q1;
                end
                default: begin
                    st_next.phase = sso_pkg::SSO_Q1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.phase <= sso_pkg::SSO_Q1;
            st_reg.work <= sso_pkg::WORK_RESET;
            // both status bits read as after power-up until a sleep
            st_reg.flags.timeout_status <= sso_pkg::TIMEOUT_RESET;
            st_reg.flags.powerdown_status <= sso_pkg::POWERDOWN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // every output comes straight from the state register, so no input reaches one in the same cycle
    assign file_addr = st_reg.insn[sso_pkg::FADDR_W-1:0];
    assign work_reg = st_reg.work;
    assign flags = st_reg.flags;
    assign file_write = st_reg.fw;
    assign sleep_ctl = st_reg.slp;
    assign phase = st_reg.phase;

endmodule

// ==== bench/sso_core_checker.sv ====
// assertions for the subtract and sleep slice, bound to sso_core
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module sso_core_checker (
    // clock and reset
    input logic core_clk,
    input logic rst,
    // instruction and operand
    input logic insn_valid,
    input logic [13:0] insn,
    input logic [7:0] file_rdata,
    // results
    input logic [7:0] work_reg,
    input sso_pkg::sso_flags_t flags,
    input sso_pkg::sso_fwrite_t file_write,
    input sso_pkg::sso_sleep_t sleep_ctl,
    input sso_pkg::sso_phase_t phase
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    sequence q1_take; phase == sso_pkg::SSO_Q1 && insn_valid && !sleep_ctl.asleep; endsequence
    sequence lit_take; q1_take ##0 insn[13:9] == 5'h1E; endsequence
    sequence file_take; q1_take ##0 insn[13:8] == 6'h02; endsequence
    sequence sleep_take; q1_take ##0 insn == 14'h0063; endsequence
    a_phase_walk:
        assert property (phase != sso_pkg::SSO_Q1 |=> phase == 2'($past(phase) + 2'h1)) else $error("phase skipped");
    a_work_at_q1:
        assert property ($changed(work_reg) |-> phase == sso_pkg::SSO_Q1) else $error("work changed mid cycle");
    a_lit_result:
        assert property (lit_take |-> ##4 work_reg == $past(insn[7:0], 4) - $past(work_reg, 4)) else $error("lit result");
    a_lit_flags:
        assert property (lit_take |-> ##4 flags.carry == ($past(insn[7:0], 4) >= $past(work_reg, 4))
            && flags.zero == (work_reg == 8'h00)) else $error("lit flags");
    a_status_kept:
        assert property (lit_take |-> ##4 flags[1:0] == $past(flags[1:0], 4)) else $error("status bits moved");
    a_file_dest:
        assert property (file_take ##0 insn[7] |-> ##4 file_write.we && $stable(work_reg)
            && file_write.data == $past(file_rdata, 3) - $past(work_reg, 4)) else $error("file write");
    a_file_carry:
        assert property (file_take |-> ##4 flags.carry == ($past(file_rdata, 3) >= $past(work_reg, 4))) else $error("carry");
    a_sleep_enter:
        assert property (sleep_take |-> ##4 sleep_ctl == 4'hF && flags[1:0] == 2'h2) else $error("sleep entry");
    a_sleep_quiet:
        assert property (sleep_take |=> ($stable(work_reg) && !file_write.we) [*4]) else $error("sleep did work");
endmodule
bind sso_core sso_core_checker u_chk(.core_clk, .rst, .insn_valid, .insn, .file_rdata, .work_reg, .flags,
    .file_write, .sleep_ctl, .phase);

// ==== bench/sso_core_bench.sv ====
// self-checking bench for the subtract and sleep slice
// assumes sso_core with its bound checker; the bench stands in for fetch and file
`timescale 1ns/1ps
module sso_core_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic insn_valid = 1'b0;
    logic wake = 1'b0;
    logic [13:0] insn = 14'h0000;
    logic [7:0] file_rdata = 8'h00;
    logic [7:0] work_reg;
    logic [6:0] file_addr;
    logic [7:0] mw = 8'h00;
    logic [1:0] st = 2'h3;
    sso_pkg::sso_flags_t flags;
    sso_pkg::sso_fwrite_t file_write;
    sso_pkg::sso_sleep_t sleep_ctl;
    sso_pkg::sso_phase_t phase;
    int fails = 0;
    int n_compared = 0;
    sso_core u_dut(.core_clk, .rst, .insn_valid, .insn, .file_addr, .file_rdata, .work_reg, .flags,
        .file_write, .sleep_ctl, .phase, .wake);
    initial forever #2.5 core_clk = ~core_clk;
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // a spare slot between ops keeps every drive on the rising edge
    task automatic run(input logic [13:0] w, input logic [7:0] fd);
        repeat (8) if (phase !== sso_pkg::SSO_Q4) @(negedge core_clk);
        @(posedge core_clk);
        insn <= w;
        insn_valid <= 1'b1;
        file_rdata <= fd;
        @(posedge core_clk);
        insn_valid <= 1'b0;
        @(negedge core_clk);
        chk(file_addr, w[6:0]);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic sub(input logic [13:0] w, input logic [7:0] fd);
        logic [7:0] op;
        logic [7:0] res;
        logic [2:0] f3;
        logic wr;
        op = w[13] ? w[7:0] : fd;
        res = op - mw;
        f3 = {op >= mw, op[3:0] >= mw[3:0], res == 8'h00};
        wr = !w[13] && w[7];
        if (!wr) mw = res;
        run(w, fd);
        chk(work_reg, mw);
        chk(flags[4:2], f3);
        chk(flags[1:0], st);
        chk(file_write.we, wr);
        if (wr) chk(file_write[14:0], {w[6:0], res});
    endtask
    ////////////////////////////////////////
    task automatic t_lit;
        logic [13:0] ks[8] = '{14'h3C01, 14'h3D02, 14'h3C01, 14'h3D00, 14'h3C10, 14'h3D0F, 14'h3CF0, 14'h3DFF};
        foreach (ks[i]) sub(ks[i], 8'h5A);
    endtask
    task automatic t_file;
        logic [13:0] ws[5] = '{14'h0285, 14'h0205, 14'h02FF, 14'h0200, 14'h0201};
        logic [7:0] fs[5] = '{8'h10, 8'h0E, 8'h00, 8'hFF, 8'h00};
        foreach (ws[i]) sub(ws[i], fs[i]);
    endtask
    task automatic t_ignored;
        run(14'h3A55, 8'h00);
        run(14'h0062, 8'h00);
        chk({sleep_ctl, file_write.we, work_reg}, {5'h00, mw});
    endtask
    task automatic t_sleep;
        run(14'h0063, 8'h00);
        st = 2'h2;
        chk({sleep_ctl, flags[1:0], work_reg}, {4'hF, st, mw});
        @(posedge core_clk);
        insn <= 14'h3C00;
        insn_valid <= 1'b1;
        repeat (8) @(posedge core_clk);
        insn_valid <= 1'b0;
        wake <= 1'b1;
        @(negedge core_clk);
        chk({sleep_ctl, phase, work_reg}, {4'h1, 2'h0, mw});
        @(posedge core_clk);
        wake <= 1'b0;
        @(negedge core_clk);
        chk({sleep_ctl, work_reg}, {4'h0, mw});
        sub(14'h3C44, 8'h00);
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk({work_reg, flags}, {8'h00, 5'h03});
        t_lit;
        t_file;
        t_ignored;
        t_sleep;
        wrap_up;
    end
    initial begin
        #5000;
        fails++;
        wrap_up;
    end
endmodule
